// ---- pmb_map.vh ----
`ifndef PMB_MAP_VH
`define PMB_MAP_VH

// Command codes.
`define PMB_CMD_OUTPUT_ON_MARGIN_COMMAND   8'h01
`define PMB_CMD_IOUT        8'h8c
`define PMB_CMD_TEMP        8'h8d
`define PMB_CMD_PROTO_REV   8'h98
`define PMB_CMD_PART_ID     8'had
`define PMB_CMD_PART_REV    8'hae
`define PMB_CMD_SCRATCH     8'hd0
`define PMB_CMD_TRIM        8'hd4
`define PMB_CMD_STEP_UP     8'hd5
`define PMB_CMD_STEP_DOWN   8'hd6
`define PMB_CMD_PCT_LIMITS  8'hd7
`define PMB_CMD_USER_OPT    8'he5
`define PMB_CMD_MISC_OPT    8'hf0

// Reset and restored values.
`define PMB_RST_SCRATCH     16'h0000
`define PMB_RST_TRIM        16'h0000
`define PMB_RST_PCT_LIMITS  8'h00
`define PMB_RST_USER_OPT    16'h0084
`define PMB_RST_MISC_OPT    16'h0013
`define PMB_STEP_UP_CLR     16'h0009
`define PMB_STEP_UP_SET     16'h000f
`define PMB_STEP_DOWN_CLR   16'hfff7
`define PMB_STEP_DOWN_SET   16'hfff1
`define PMB_PROTO_REV_VAL   8'h33
`define PMB_BLOCK_COUNT     8'h02

// Field positions of the on/off/margin command byte.
`define PMB_OP_ON_BIT       7
`define PMB_OP_OFF_BIT      6
`define PMB_OP_MARGIN_HI    5
`define PMB_OP_MARGIN_LO    2

// Command shape codes.
`define PMB_KIND_NONE       2'h0
`define PMB_KIND_BYTE       2'h1
`define PMB_KIND_WORD       2'h2
`define PMB_KIND_BLOCK      2'h3

// Setpoint selection codes.
`define PMB_SEL_NOMINAL     2'h0
`define PMB_SEL_LOW         2'h1
`define PMB_SEL_HIGH        2'h2

// Strap settling count after reset release.
`define PMB_INIT_COUNT      3'h5

`endif

// ---- pmb_cmd_bank.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pmb_map.vh"

// Functional notes
// - Part identifier: block read, count two, LSB first.
// - Part revision: read-only block read, count two.
// - Command 8Ch returns measured output current.
// - Command 8Dh returns die temperature.
// - Command 98h reports protocol revision 1.3.
// - Reference trim adds signed offset, default zero.
// - Up step restores by strap: 17.6/29.3 mV.
// - Down step restores fff7h or fff1h by strap.
// - Percent limits register, default 00h.
// - Option registers default 0084h and 0013h.
// - Backed bits save and restore; others volatile.
// - On bit combines with control pin.
// - Margin field bits 5..2 selects setpoint.
// - Mode holds until new write or pin change.
// - Loop slave: on/off command NACKed, fault, alert.
// - Bit7 on, bit6 off, bits1..0 read-only.
// - On bit clear with cmd_gate_on: switching off, drivers low.
// - On bit set: enable only if gated ok.
// - Off bit selects immediate or soft stop.
// - On and off together: invalid data, alert.
// - Margin codes decoded; others invalid data.
module pmb_cmd_bank #(
   parameter [6:0]  DEV_ADDR = 7'h10,
   parameter [15:0] PART_ID  = 16'h1234,  // Arbitrary value.
   parameter [15:0] PART_REV = 16'h0002   // Arbitrary value.
) (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output wire        sda_oe,
   output wire        alert_out,
   output wire        alert_oe,
   input  wire        enable_control_pin,
   input  wire        high_step_strap_flag,
   input  wire        low_step_strap_flag,
   input  wire [15:0] iout_value,
   input  wire [15:0] temp_value,
   input  wire        vin_above_uvlo,
   input  wire        fault_present,
   input  wire        cmd_gate_on,
   input  wire        pin_gate_on,
   input  wire        loop_slave,
   input  wire        clear_faults,
   input  wire        nvm_store,
   input  wire        nvm_restore,
   output wire        switching_enable,
   output wire        drivers_low,
   output wire        soft_off,
   output wire [1:0]  margin_sel,
   output wire        ovuv_ignore,
   output wire [15:0] error_amp_reference,
   output wire [7:0]  percent_window_limits,
   output wire [15:0] user_options,
   output wire [15:0] misc_options,
   output wire        cml_flag,
   output wire        ivd_flag,
   output wire        ivc_flag
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_AACK = 3'h2;
   localparam [2:0] S_CMD  = 3'h3;
   localparam [2:0] S_DACK = 3'h4;
   localparam [2:0] S_WR   = 3'h5;
   localparam [2:0] S_RD   = 3'h6;
   localparam [2:0] S_RACK = 3'h7;

   // Order in the sync vector: scl, sda, control pin, up strap, down strap.
   reg  [4:0]  sy1_reg;
   reg  [4:0]  sy2_reg;
   reg  [4:0]  sy3_reg;
   reg  [4:0]  cln_reg;
   reg         scl_d_reg;
   reg         sda_d_reg;
   reg  [2:0]  st_reg;
   reg  [3:0]  bit_reg;
   reg  [7:0]  sh_reg;
   reg  [7:0]  cmd_reg;
   reg  [1:0]  idx_reg;
   reg  [7:0]  wlo_reg;
   reg         rd_mode_reg;
   reg         mack_reg;
   reg         sda_oe_reg;
   reg         op_on_reg;
   reg         op_off_reg;
   reg  [3:0]  op_margin_reg;
   reg  [15:0] scratch_reg;
   reg  [15:0] trim_reg;
   reg  [15:0] step_up_reg;
   reg  [15:0] step_dn_reg;
   reg  [7:0]  pct_reg;
   reg  [15:0] uopt_reg;
   reg  [15:0] mopt_reg;
   reg  [15:0] nv_scratch_reg;
   reg  [15:0] nv_trim_reg;
   reg  [7:0]  nv_pct_reg;
   reg  [15:0] nv_uopt_reg;
   reg  [15:0] nv_mopt_reg;
   reg  [2:0]  init_reg;
   reg         cml_reg;
   reg         ivd_reg;
   reg         ivc_reg;
   reg         alert_oe_reg;
   reg         sw_en_reg;
   reg         drv_low_reg;
   reg         soft_off_reg;
   reg  [1:0]  sel_reg;
   reg         ign_reg;
   reg  [15:0] eref_reg;
   reg  [15:0] rd_word;
   reg  [1:0]  kind;
   reg         writable;
   reg  [7:0]  rd_byte;
   reg  [1:0]  sel_next;
   reg  [15:0] eref_next;

   wire scl       = cln_reg[0];
   wire sda       = cln_reg[1];
   wire pin_on    = cln_reg[2];
   wire scl_rise  = scl & ~scl_d_reg;
   wire scl_fall  = ~scl & scl_d_reg;
   wire start_ev  = scl & scl_d_reg & sda_d_reg & ~sda;
   wire stop_ev   = scl & scl_d_reg & ~sda_d_reg & sda;
   wire byte_done = scl_fall & (bit_reg == 4'h8);
   wire [3:0] wr_margin = sh_reg[`PMB_OP_MARGIN_HI:`PMB_OP_MARGIN_LO];
   wire margin_ok = (wr_margin[3:2] == 2'b00) |
                    (wr_margin == 4'b0101) | (wr_margin == 4'b0110) |
                    (wr_margin == 4'b1001) | (wr_margin == 4'b1010);
   wire run = vin_above_uvlo & ~fault_present & (cmd_gate_on | pin_gate_on) &
              (~cmd_gate_on | op_on_reg) & (~pin_gate_on | pin_on);

   assign sda_out               = 1'b0;
   assign sda_oe                = sda_oe_reg;
   assign alert_out             = 1'b0;
   assign alert_oe              = alert_oe_reg;
   assign switching_enable      = sw_en_reg;
   assign drivers_low           = drv_low_reg;
   assign soft_off              = soft_off_reg;
   assign margin_sel            = sel_reg;
   assign ovuv_ignore           = ign_reg;
   assign error_amp_reference   = eref_reg;
   assign percent_window_limits = pct_reg;
   assign user_options          = uopt_reg;
   assign misc_options          = mopt_reg;
   assign cml_flag              = cml_reg;
   assign ivd_flag              = ivd_reg;
   assign ivc_flag              = ivc_reg;

   always @* begin
      rd_word  = 16'h0000;
      kind     = `PMB_KIND_WORD;
      writable = 1'b1;
      case (cmd_reg)
         `PMB_CMD_OUTPUT_ON_MARGIN_COMMAND: begin
            rd_word  = {8'h00, op_on_reg, op_off_reg, op_margin_reg, 2'b00};
            kind     = `PMB_KIND_BYTE;
         end
         `PMB_CMD_IOUT: begin
            rd_word  = iout_value;
            writable = 1'b0;
         end
         `PMB_CMD_TEMP: begin
            rd_word  = temp_value;
            writable = 1'b0;
         end
         `PMB_CMD_PROTO_REV: begin
            rd_word  = {8'h00, `PMB_PROTO_REV_VAL};
            kind     = `PMB_KIND_BYTE;
            writable = 1'b0;
         end
         `PMB_CMD_PART_ID: begin
            rd_word  = PART_ID;
            kind     = `PMB_KIND_BLOCK;
            writable = 1'b0;
         end
         `PMB_CMD_PART_REV: begin
            rd_word  = PART_REV;
            kind     = `PMB_KIND_BLOCK;
            writable = 1'b0;
         end
         `PMB_CMD_SCRATCH:   rd_word = scratch_reg;
         `PMB_CMD_TRIM:      rd_word = trim_reg;
         `PMB_CMD_STEP_UP:   rd_word = step_up_reg;
         `PMB_CMD_STEP_DOWN: rd_word = step_dn_reg;
         `PMB_CMD_PCT_LIMITS: begin
            rd_word  = {8'h00, pct_reg};
            kind     = `PMB_KIND_BYTE;
         end
         `PMB_CMD_USER_OPT:  rd_word = uopt_reg;
         `PMB_CMD_MISC_OPT:  rd_word = mopt_reg;
         default: begin
            kind     = `PMB_KIND_NONE;
            writable = 1'b0;
         end
      endcase
      // Block reads prepend the count; bytes past the end read as all ones until the two-bit index wraps back to the first byte.
      if (kind == `PMB_KIND_BLOCK) begin
         case (idx_reg)
            2'h0:    rd_byte = `PMB_BLOCK_COUNT;
            2'h1:    rd_byte = rd_word[7:0];
            2'h2:    rd_byte = rd_word[15:8];
            default: rd_byte = 8'hff;
         endcase
      end else if (kind == `PMB_KIND_WORD) begin
         rd_byte = (idx_reg == 2'h0) ? rd_word[7:0] : (idx_reg == 2'h1) ? rd_word[15:8] : 8'hff;
      end else begin
         rd_byte = (idx_reg == 2'h0) ? rd_word[7:0] : 8'hff;
      end
   end

   always @* begin
      sel_next = `PMB_SEL_NOMINAL;
      if ((op_margin_reg == 4'b0101) | (op_margin_reg == 4'b0110)) begin
         sel_next = `PMB_SEL_LOW;
      end else if ((op_margin_reg == 4'b1001) | (op_margin_reg == 4'b1010)) begin
         sel_next = `PMB_SEL_HIGH;
      end
      // The down step is stored already negative, so both steps are added.
      case (sel_next)
         `PMB_SEL_LOW:  eref_next = trim_reg + step_dn_reg;
         `PMB_SEL_HIGH: eref_next = trim_reg + step_up_reg;
         default:       eref_next = trim_reg;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         sy1_reg        <= 5'h03;
         sy2_reg        <= 5'h03;
         sy3_reg        <= 5'h03;
         cln_reg        <= 5'h03;
         scl_d_reg      <= 1'b1;
         sda_d_reg      <= 1'b1;
         st_reg         <= S_IDLE;
         bit_reg        <= 4'h0;
         sh_reg         <= 8'h00;
         cmd_reg        <= 8'h00;
         idx_reg        <= 2'h0;
         wlo_reg        <= 8'h00;
         rd_mode_reg    <= 1'b0;
         mack_reg       <= 1'b0;
         sda_oe_reg     <= 1'b0;
         op_on_reg      <= 1'b0;
         op_off_reg     <= 1'b0;
         op_margin_reg  <= 4'h0;
         scratch_reg    <= `PMB_RST_SCRATCH;
         trim_reg       <= `PMB_RST_TRIM;
         step_up_reg    <= `PMB_STEP_UP_CLR;
         step_dn_reg    <= `PMB_STEP_DOWN_CLR;
         pct_reg        <= `PMB_RST_PCT_LIMITS;
         uopt_reg       <= `PMB_RST_USER_OPT;
         mopt_reg       <= `PMB_RST_MISC_OPT;
         nv_scratch_reg <= `PMB_RST_SCRATCH;
         nv_trim_reg    <= `PMB_RST_TRIM;
         nv_pct_reg     <= `PMB_RST_PCT_LIMITS;
         nv_uopt_reg    <= `PMB_RST_USER_OPT;
         nv_mopt_reg    <= `PMB_RST_MISC_OPT;
         init_reg       <= `PMB_INIT_COUNT;
         cml_reg        <= 1'b0;
         ivd_reg        <= 1'b0;
         ivc_reg        <= 1'b0;
         alert_oe_reg   <= 1'b0;
         sw_en_reg      <= 1'b0;
         drv_low_reg    <= 1'b1;
         soft_off_reg   <= 1'b0;
         sel_reg        <= `PMB_SEL_NOMINAL;
         ign_reg        <= 1'b0;
         eref_reg       <= `PMB_RST_TRIM;
      end else begin
         sy1_reg   <= {low_step_strap_flag, high_step_strap_flag, enable_control_pin, sda_in, scl_in};
         sy2_reg   <= sy1_reg;
         sy3_reg   <= sy2_reg;
         cln_reg   <= (sy2_reg & sy3_reg) | (cln_reg & (sy2_reg ^ sy3_reg));
         scl_d_reg <= scl;
         sda_d_reg <= sda;

         // Cleared first, so a same-cycle event still sets its flag.
         if (clear_faults) begin
            cml_reg <= 1'b0;
            ivd_reg <= 1'b0;
            ivc_reg <= 1'b0;
         end
         if (scl_rise & (st_reg != S_RD)) begin
            sh_reg  <= {sh_reg[6:0], sda};
            bit_reg <= bit_reg + 4'h1;
         end

         case (st_reg)
            S_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            S_ADDR: begin
               if (byte_done) begin
                  if (sh_reg[7:1] == DEV_ADDR) begin
                     sda_oe_reg  <= 1'b1;
                     rd_mode_reg <= sh_reg[0];
                     st_reg      <= S_AACK;
                  end else begin
                     st_reg      <= S_IDLE;
                  end
               end
            end
            S_AACK: begin
               if (scl_fall) begin
                  bit_reg <= 4'h0;
                  if (rd_mode_reg) begin
                     idx_reg    <= 2'h0;
                     sda_oe_reg <= ~rd_byte[7];
                     sh_reg     <= {rd_byte[6:0], 1'b0};
                     bit_reg    <= 4'h1;
                     st_reg     <= S_RD;
                  end else begin
                     sda_oe_reg <= 1'b0;
                     st_reg     <= S_CMD;
                  end
               end
            end
            S_CMD: begin
               if (byte_done) begin
                  cmd_reg <= sh_reg;
                  idx_reg <= 2'h0;
                  // A loop slave must not see the on/off command at all.
                  if ((sh_reg == `PMB_CMD_OUTPUT_ON_MARGIN_COMMAND) & loop_slave) begin
                     ivc_reg <= 1'b1;
                     cml_reg <= 1'b1;
                     st_reg  <= S_IDLE;
                  end else begin
                     sda_oe_reg <= 1'b1;
                     st_reg     <= S_DACK;
                  end
               end
            end
            S_DACK: begin
               if (scl_fall) begin
                  sda_oe_reg <= 1'b0;
                  bit_reg    <= 4'h0;
                  st_reg     <= S_WR;
                  if (kind == `PMB_KIND_NONE) begin
                     ivc_reg <= 1'b1;
                     cml_reg <= 1'b1;
                     st_reg  <= S_IDLE;
                  end
               end
            end
            S_WR: begin
               if (byte_done) begin
                  idx_reg <= idx_reg + 2'h1;
                  if (!writable || (kind == `PMB_KIND_BYTE && idx_reg != 2'h0) ||
                      (kind == `PMB_KIND_WORD && idx_reg > 2'h1)) begin
                     ivc_reg <= 1'b1;
                     cml_reg <= 1'b1;
                     st_reg  <= S_IDLE;
                  end else begin
                     sda_oe_reg <= 1'b1;
                     st_reg     <= S_DACK;
                     if (kind == `PMB_KIND_BYTE) begin
                        if (cmd_reg == `PMB_CMD_PCT_LIMITS) begin
                           pct_reg <= sh_reg;
                        end else if ((sh_reg[`PMB_OP_ON_BIT] & sh_reg[`PMB_OP_OFF_BIT]) | ~margin_ok) begin
                           ivd_reg <= 1'b1;
                           cml_reg <= 1'b1;
                        end else begin
                           op_on_reg     <= sh_reg[`PMB_OP_ON_BIT];
                           op_off_reg    <= sh_reg[`PMB_OP_OFF_BIT];
                           op_margin_reg <= wr_margin;
                        end
                     end else if (idx_reg == 2'h0) begin
                        wlo_reg <= sh_reg;
                     end else begin
                        case (cmd_reg)
                           `PMB_CMD_SCRATCH:   scratch_reg <= {sh_reg, wlo_reg};
                           `PMB_CMD_TRIM:      trim_reg    <= {sh_reg, wlo_reg};
                           `PMB_CMD_STEP_UP:   step_up_reg <= {sh_reg, wlo_reg};
                           `PMB_CMD_STEP_DOWN: step_dn_reg <= {sh_reg, wlo_reg};
                           `PMB_CMD_USER_OPT:  uopt_reg    <= {sh_reg, wlo_reg};
                           default:            mopt_reg    <= {sh_reg, wlo_reg};
                        endcase
                     end
                  end
               end
            end
            S_RD: begin
               if (scl_fall) begin
                  if (bit_reg == 4'h8) begin
                     idx_reg    <= idx_reg + 2'h1;
                     sda_oe_reg <= 1'b0;
                     bit_reg    <= 4'h0;
                     st_reg     <= S_RACK;
                  end else begin
                     sda_oe_reg <= ~sh_reg[7];
                     sh_reg     <= {sh_reg[6:0], 1'b0};
                     bit_reg    <= bit_reg + 4'h1;
                  end
               end
            end
            S_RACK: begin
               if (scl_rise) begin
                  mack_reg <= ~sda;
               end
               if (scl_fall) begin
                  if (mack_reg) begin
                     sda_oe_reg <= ~rd_byte[7];
                     sh_reg     <= {rd_byte[6:0], 1'b0};
                     bit_reg    <= 4'h1;
                     st_reg     <= S_RD;
                  end else begin
                     st_reg     <= S_IDLE;
                  end
               end
            end
            default: st_reg <= S_IDLE;
         endcase

         if (start_ev) begin
            st_reg     <= S_ADDR;
            bit_reg    <= 4'h0;
            sda_oe_reg <= 1'b0;
         end else if (stop_ev) begin
            st_reg     <= S_IDLE;
            sda_oe_reg <= 1'b0;
         end

         // Restore and strap defaults use settled strap inputs only.
         if (init_reg != 3'h0) begin
            init_reg <= init_reg - 3'h1;
         end
         if (nvm_store) begin
            nv_scratch_reg <= scratch_reg;
            nv_trim_reg    <= trim_reg;
            nv_pct_reg     <= pct_reg;
            nv_uopt_reg    <= uopt_reg;
            nv_mopt_reg    <= mopt_reg;
         end
         if (nvm_restore) begin
            scratch_reg <= nv_scratch_reg;
            trim_reg    <= nv_trim_reg;
            pct_reg     <= nv_pct_reg;
            uopt_reg    <= nv_uopt_reg;
            mopt_reg    <= nv_mopt_reg;
         end
         if (nvm_restore | (init_reg == 3'h1)) begin
            step_up_reg <= cln_reg[3] ? `PMB_STEP_UP_SET : `PMB_STEP_UP_CLR;
            step_dn_reg <= cln_reg[4] ? `PMB_STEP_DOWN_SET : `PMB_STEP_DOWN_CLR;
         end

         alert_oe_reg <= cml_reg | ivd_reg | ivc_reg;

         sw_en_reg   <= run;
         drv_low_reg <= ~run;
         if (sw_en_reg & ~run) begin
            soft_off_reg <= op_off_reg;
         end
         sel_reg  <= sel_next;
         ign_reg  <= (op_margin_reg == 4'b0001) | (op_margin_reg == 4'b0101) | (op_margin_reg == 4'b1001);
         eref_reg <= eref_next;
      end
   end

endmodule
`default_nettype wire

// ---- pmb_cmd_bank_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmb_cmd_bank_sva (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       scl_in,
   input wire logic       enable_control_pin,
   input wire logic       vin_above_uvlo,
   input wire logic       fault_present,
   input wire logic       cmd_gate_on,
   input wire logic       pin_gate_on,
   input wire logic       clear_faults,
   input wire logic       switching_enable,
   input wire logic       drivers_low,
   input wire logic [1:0] margin_sel,
   input wire logic       alert_oe,
   input wire logic       cml_flag,
   input wire logic       ivd_flag,
   input wire logic       ivc_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Eight quiet cycles cover pin sync, commit and update.
   sequence inputs_quiet;
      ($stable(scl_in) && $stable(enable_control_pin) && $stable(vin_above_uvlo) && $stable(fault_present)
       && $stable(cmd_gate_on) && $stable(pin_gate_on) && !clear_faults) [*8];
   endsequence
   a_drivers_off_low: assert property (drivers_low == !switching_enable)
      else $error("drivers not low while off");
   a_mode_holds: assert property (inputs_quiet |-> $stable(margin_sel) && $stable(switching_enable))
      else $error("mode changed while quiet");
   a_switch_gated: assert property ($rose(switching_enable) |-> $past(vin_above_uvlo) && !$past(fault_present))
      else $error("switching on without gates");
   a_alert_lags_flags: assert property (alert_oe == $past(cml_flag || ivd_flag || ivc_flag))
      else $error("alert not following flags");
   a_ivd_sets_cml: assert property ($rose(ivd_flag) |-> cml_flag)
      else $error("ivd without cml");
   a_ivc_sets_cml: assert property ($rose(ivc_flag) |-> cml_flag)
      else $error("ivc without cml");
   a_ivd_sticky: assert property (ivd_flag && !clear_faults |=> ivd_flag)
      else $error("ivd dropped without clear");
   a_margin_sel_legal: assert property (margin_sel != 2'h3)
      else $error("margin code illegal");
endmodule
bind pmb_cmd_bank pmb_cmd_bank_sva i_sva (.*);
`default_nettype wire

// ---- pmb_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmb_host (
   output logic     scl,
   output logic     sda_low,
   input  wire logic sda
);
   // Half periods of 15 clocks cover the pin sync; QTR keeps host edges on falling clock edges.
   localparam int HALF = 600;
   localparam int QTR  = 160;
   initial begin
      scl = 1'h1;
      sda_low = 1'h0;
   end
   task automatic start();
      sda_low = 1'h0;
      #QTR scl = 1'h1;
      #HALF sda_low = 1'h1;
      #HALF scl = 1'h0;
   endtask
   task automatic stop();
      #QTR sda_low = 1'h1;
      #HALF scl = 1'h1;
      #HALF sda_low = 1'h0;
      #HALF;
   endtask
   task automatic bits9(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         #QTR sda_low = !d[i];
         #HALF scl = 1'h1;
         #HALF q[i] = sda;
         scl = 1'h0;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmb_map.vh"
module tb;
   localparam logic [6:0]  ADDR = 7'h10;
   localparam logic [15:0] PID  = 16'h5a3c;  // Arbitrary value.
   localparam logic [15:0] PREV = 16'h0007;  // Arbitrary value.
   logic        clk, rst_b, enable_control_pin, high_step_strap_flag, low_step_strap_flag, vin_above_uvlo;
   logic        fault_present, cmd_gate_on, pin_gate_on, loop_slave, clear_faults, nvm_store, nvm_restore;
   logic [15:0] iout_value, temp_value;
   wire logic   scl_in, host_low, sda_out, sda_oe, alert_out, alert_oe, switching_enable, drivers_low, soft_off;
   wire logic   ovuv_ignore, cml_flag, ivd_flag, ivc_flag;
   wire logic [1:0]  margin_sel;
   wire logic [7:0]  percent_window_limits;
   wire logic [15:0] error_amp_reference, user_options, misc_options;
   wire logic   sda_in = !(host_low || sda_oe);
   int          failures, compares;
   logic        cmd_ack;
   pmb_host i_host (.scl(scl_in), .sda_low(host_low), .sda(sda_in));
   pmb_cmd_bank #(.DEV_ADDR(ADDR), .PART_ID(PID), .PART_REV(PREV)) i_dut (.*);
   initial begin
      clk = 1'h0;
      forever #20 clk = !clk;
   end
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'h1;
      @(negedge clk) s = 1'h0;
      repeat (2) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
      logic [8:0] q;
      i_host.start();
      i_host.bits9({ADDR, 1'h0, 1'h1}, q);
      i_host.bits9({cmd, 1'h1}, q);
      cmd_ack = !q[0];
      for (int i = 0; i < n; i++) i_host.bits9({d[8*i +: 8], 1'h1}, q);
      i_host.stop();
   endtask
   task automatic rd(input logic [7:0] cmd, input int n, output logic [23:0] v);
      logic [8:0] q;
      v = 24'h0;
      i_host.start();
      i_host.bits9({ADDR, 1'h0, 1'h1}, q);
      i_host.bits9({cmd, 1'h1}, q);
      i_host.start();
      i_host.bits9({ADDR, 1'h1, 1'h1}, q);
      for (int i = 0; i < n; i++) begin
         i_host.bits9({8'hff, i == n - 1}, q);
         v[8*i +: 8] = q[8:1];
      end
      i_host.stop();
   endtask
   // Result is {valid, ignore over/under voltage, selection}.
   function automatic logic [3:0] mdec(input logic [3:0] c);
      case (c)
         4'h0, 4'h2, 4'h3: return {2'h2, `PMB_SEL_NOMINAL};
         4'h1: return {2'h3, `PMB_SEL_NOMINAL};
         4'h5: return {2'h3, `PMB_SEL_LOW};
         4'h6: return {2'h2, `PMB_SEL_LOW};
         4'h9: return {2'h3, `PMB_SEL_HIGH};
         4'ha: return {2'h2, `PMB_SEL_HIGH};
         default: return 4'h0;
      endcase
   endfunction
   initial begin
      repeat (95000) @(posedge clk);
      failures++;
      final_report();
   end
   initial begin
      logic [23:0] v;
      logic [7:0]  prev;
      logic [3:0]  e;
      logic [7:0]  bad [2];
      bad = '{8'h8c, 8'h55};
      {enable_control_pin, high_step_strap_flag, low_step_strap_flag, fault_present, pin_gate_on} = 5'h0;
      {loop_slave, clear_faults, nvm_store, nvm_restore} = 4'h0;
      {vin_above_uvlo, cmd_gate_on} = 2'h3;
      iout_value = 16'h1a2b;
      temp_value = 16'h0c3d;
      rst_b = 1'h0;
      repeat (4) @(negedge clk);
      rst_b = 1'h1;
      repeat (8) @(negedge clk);
      check("user_options", user_options, `PMB_RST_USER_OPT);
      check("misc_options", misc_options, `PMB_RST_MISC_OPT);
      check("pct_limits", percent_window_limits, `PMB_RST_PCT_LIMITS);
      check("reference", error_amp_reference, `PMB_RST_TRIM);
      check("drivers_low", drivers_low, 1'h1);
      rd(`PMB_CMD_PROTO_REV, 1, v); check("proto_rev", v, `PMB_PROTO_REV_VAL);
      rd(`PMB_CMD_IOUT, 2, v); check("iout", v, iout_value);
      rd(`PMB_CMD_TEMP, 2, v); check("temp", v, temp_value);
      rd(`PMB_CMD_PART_ID, 3, v); check("part_id", v, {PID, 8'h02});
      rd(`PMB_CMD_PART_REV, 3, v); check("part_rev", v, {PREV, 8'h02});
      foreach (bad[i]) begin
         wr(bad[i], 16'h5555, 2); check("ivc_flag", ivc_flag, 1'h1);
         pulse(clear_faults);
      end
      $display("test reads done");
      prev = 8'h80;
      for (int c = 0; c < 16; c++) begin
         wr(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, {8'h0, 2'h2, c[3:0], 2'h3}, 1);
         if (mdec(c[3:0]) !== 4'h0) prev = {2'h2, c[3:0], 2'h0};
         e = mdec(prev[5:2]);
         check("ivd_flag", ivd_flag, mdec(c[3:0]) === 4'h0);
         check("margin_sel", margin_sel, e[1:0]);
         check("ovuv_ignore", ovuv_ignore, e[2]);
         check("reference", error_amp_reference, e[1:0] == `PMB_SEL_HIGH ? `PMB_STEP_UP_CLR :
               e[1:0] == `PMB_SEL_LOW ? `PMB_STEP_DOWN_CLR : 16'h0);
         check("switching", switching_enable, 1'h1);
         rd(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, 1, v); check("op_readback", v, prev);
         pulse(clear_faults);
      end
      wr(`PMB_CMD_TRIM, 16'h0010, 2); check("ref_trim", error_amp_reference, 16'h0019);
      wr(`PMB_CMD_SCRATCH, 16'h1111, 2);
      pulse(nvm_store);
      @(negedge clk) {high_step_strap_flag, low_step_strap_flag} = 2'h3;
      wr(`PMB_CMD_SCRATCH, 16'h2222, 2);
      pulse(nvm_restore);
      rd(`PMB_CMD_SCRATCH, 2, v); check("scratch", v, 16'h1111);
      check("ref_strap", error_amp_reference, 16'h001f);
      rd(`PMB_CMD_STEP_DOWN, 2, v); check("step_dn", v, `PMB_STEP_DOWN_SET);
      wr(`PMB_CMD_PCT_LIMITS, 16'h0005, 1); check("pct_wr", percent_window_limits, 8'h05);
      $display("test margins done");
      wr(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, 16'h00c0, 1); check("ivd_both", ivd_flag & cml_flag & alert_oe, 1'h1);
      check("switching", switching_enable, 1'h1);
      pulse(clear_faults); check("alert", alert_oe, 1'h0);
      wr(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, 16'h0040, 1); check("soft_off", {switching_enable, soft_off}, 2'h1);
      check("drivers_low", drivers_low, 1'h1);
      wr(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, 16'h0080, 1);
      wr(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, 16'h0000, 1); check("hard_off", {switching_enable, soft_off}, 2'h0);
      @(negedge clk) pin_gate_on = 1'h1;
      wr(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, 16'h0080, 1); check("pin_low", switching_enable, 1'h0);
      @(negedge clk) enable_control_pin = 1'h1;
      repeat (8) @(negedge clk); check("pin_high", switching_enable, 1'h1);
      @(negedge clk) fault_present = 1'h1;
      repeat (8) @(negedge clk); check("fault_off", switching_enable, 1'h0);
      @(negedge clk) loop_slave = 1'h1;
      wr(`PMB_CMD_OUTPUT_ON_MARGIN_COMMAND, 16'h0000, 1); check("slave", {cmd_ack, ivc_flag}, 2'h1);
      $display("test on off done");
      final_report();
   end
endmodule
`default_nettype wire
